// >>> rtl/dpg_gpio.sv
// two 8-bit gpio ports with pull-ups, peripheral override and standby
//
// How it works
// - direction bit 1 makes the pin an output driven from its latch
// - outside standby, a gpio output pin shows its latch value one cycle later
// - data writes always load the latch; only outputs show it
// - reading an output pin's data bit returns the latch
// - direction bit 0 makes the pin an undriven input
// - input pins read the pin level; read-modify-write reads the latch
// - a peripheral output enable hands the pin's output to it
// - peripheral-driven pins read the pin level; rmw reads the latch
// - pin level reads the same whether a peripheral uses it or not
// - reset clears all direction bits, so all pins start as inputs
// - standby with pin-state bit 1 floats pins, blocks inputs low
// - standby with pin-state bit 0 keeps pins and output levels
// - pull-up bit 1 connects the internal pull-up
// - a pin driving low never has its pull-up connected
// - port 4 analog-disable bit 0 blocks digital input on pins 0-3
// - reset clears the analog-disable register
// - clock and data-in pins stay live in standby if irq enabled
`timescale 1ns/1ps
module dpg_gpio import dpg_pkg::*; (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [DPG_AW-1:0] addr_i,
  input wire logic [DPG_DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic rmw_i,
  output logic [DPG_DW-1:0] rdata_o,
  input wire logic stop_mode_i,
  input wire logic watch_mode_i,
  input wire logic sck_irq_en_i,
  input wire logic sin_irq_en_i,
  input wire dpg_periph_t port1_periph_i,
  input wire dpg_periph_t port4_periph_i,
  input wire logic [DPG_DW-1:0] port1_pin_i,
  input wire logic [DPG_DW-1:0] port4_pin_i,
  output dpg_drv_t port1_drv_o,
  output dpg_drv_t port4_drv_o,
  output logic [DPG_DW-1:0] port1_in_o,
  output logic [DPG_DW-1:0] port4_in_o
);

  typedef struct packed {
    logic [DPG_DW-1:0] p1_dat;
    logic [DPG_DW-1:0] p1_dir;
    logic [DPG_DW-1:0] p1_pul;
    logic [DPG_DW-1:0] p4_dat;
    logic [DPG_DW-1:0] p4_dir;
    logic [DPG_DW-1:0] p4_pul;
    logic [DPG_NA-1:0] aid;
    logic standby_pin_state;
    logic stby;
    logic hiz;
    dpg_drv_t drv1;
    dpg_drv_t drv4;
    logic [DPG_DW-1:0] in1;
    logic [DPG_DW-1:0] in4;
    logic [DPG_DW-1:0] rdata;
  } dpg_st_t;

  dpg_st_t st_q;
  dpg_st_t st_d;
  logic [2*DPG_DW-1:0] sync_lvl;
  logic [DPG_DW-1:0] lvl1;
  logic [DPG_DW-1:0] lvl4;

  dpg_pin_sync #(
    .W(2*DPG_DW)
  ) u_sync (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .pin_i({port4_pin_i, port1_pin_i}),
    .lvl_o(sync_lvl)
  );

  assign lvl1 = sync_lvl[DPG_DW-1:0];
  assign lvl4 = sync_lvl[2*DPG_DW-1:DPG_DW];

  // normal-mode pad drive for one port
  function automatic dpg_drv_t pad_drive(
    input logic [DPG_DW-1:0] dat,
    input logic [DPG_DW-1:0] dir,
    input logic [DPG_DW-1:0] pul,
    input dpg_periph_t per
  );
    dpg_drv_t d;
    logic [DPG_DW-1:0] drive;
    drive = dir | per.oe;
    d.lvl = (per.oe & per.dat) | (~per.oe & dat & dir);
    d.oe_b = ~drive;
    // pull-up drops out whenever the pad is pulled low by us
    d.pu = pul & ~(drive & ~d.lvl);
    return d;
  endfunction

  // data register read: latch for gpio outputs and rmw, else pin level
  function automatic logic [DPG_DW-1:0] data_read(
    input logic [DPG_DW-1:0] dat,
    input logic [DPG_DW-1:0] dir,
    input logic [DPG_DW-1:0] poe,
    input logic [DPG_DW-1:0] lvl,
    input logic rmw
  );
    logic [DPG_DW-1:0] own;
    own = dir & ~poe;
    if (rmw) begin
      data_read = dat;
    end else begin
      data_read = (own & dat) | (~own & lvl);
    end
  endfunction

  // float every pad, keeping pull-up choice
  function automatic dpg_drv_t pad_float(input logic [DPG_DW-1:0] pul);
    dpg_drv_t d;
    d.lvl = '0;
    d.oe_b = DPG_ALL_OFF;
    d.pu = pul;
    return d;
  endfunction

  logic stby_now;
  logic [DPG_DW-1:0] g1;
  logic [DPG_DW-1:0] g4;
  logic [DPG_DW-1:0] live4;
  logic [DPG_DW-1:0] aid_mask;

  always_comb begin
    st_d = st_q;
    stby_now = stop_mode_i | watch_mode_i;
    st_d.stby = stby_now;

    // register writes
    if (wr_i) begin
      case (addr_i)
        DPG_P1_DAT: st_d.p1_dat = wdata_i;
        DPG_P1_DIR: st_d.p1_dir = wdata_i;
        DPG_P1_PUL: st_d.p1_pul = wdata_i;
        DPG_P4_DAT: st_d.p4_dat = wdata_i;
        DPG_P4_DIR: st_d.p4_dir = wdata_i;
        DPG_P4_PUL: st_d.p4_pul = wdata_i;
        DPG_AID_UP: st_d.aid = wdata_i[DPG_NA-1:0];
        DPG_STBY_CTL: st_d.standby_pin_state = wdata_i[DPG_SPL_BIT];
        default: st_d.standby_pin_state = st_q.standby_pin_state;
      endcase
    end

    // pin-state choice is taken once, on standby entry
    if (!stby_now) begin
      st_d.hiz = 1'b0;
    end else if (!st_q.stby) begin
      st_d.hiz = st_q.standby_pin_state;
    end else begin
      st_d.hiz = st_q.hiz;
    end

    if (st_d.hiz) begin
      st_d.drv1 = pad_float(st_q.p1_pul);
      st_d.drv4 = pad_float(st_q.p4_pul);
    end else if (stby_now) begin
      // standby without float freezes pads at their levels
      st_d.drv1 = st_q.drv1;
      st_d.drv4 = st_q.drv4;
    end else begin
      st_d.drv1 = pad_drive(st_q.p1_dat, st_q.p1_dir, st_q.p1_pul,
                            port1_periph_i);
      st_d.drv4 = pad_drive(st_q.p4_dat, st_q.p4_dir, st_q.p4_pul,
                            port4_periph_i);
    end

    // input blocking in float mode; irq pins may stay live
    live4 = '0;
    live4[DPG_SCK_PIN] = sck_irq_en_i;
    live4[DPG_SIN_PIN] = sin_irq_en_i;
    aid_mask = {{(DPG_DW-DPG_NA){1'b1}}, st_q.aid};
    g1 = st_d.hiz ? '0 : lvl1;
    g4 = (st_d.hiz ? (lvl4 & live4) : lvl4) & aid_mask;
    st_d.in1 = g1;
    st_d.in4 = g4;

    // read data stands for one cycle only
    st_d.rdata = DPG_RST_RD;
    if (rd_i) begin
      case (addr_i)
        DPG_P1_DAT: st_d.rdata = data_read(st_q.p1_dat, st_q.p1_dir,
                                 port1_periph_i.oe, st_q.in1, rmw_i);
        DPG_P1_DIR: st_d.rdata = st_q.p1_dir;
        DPG_P1_PUL: st_d.rdata = st_q.p1_pul;
        DPG_P4_DAT: st_d.rdata = data_read(st_q.p4_dat, st_q.p4_dir,
                                 port4_periph_i.oe, st_q.in4, rmw_i);
        DPG_P4_DIR: st_d.rdata = st_q.p4_dir;
        DPG_P4_PUL: st_d.rdata = st_q.p4_pul;
        DPG_AID_UP: st_d.rdata = {{(DPG_DW-DPG_NA){1'b0}}, st_q.aid};
        DPG_STBY_CTL: st_d.rdata[DPG_SPL_BIT] = st_q.standby_pin_state;
        DPG_STATUS: begin
          st_d.rdata[DPG_ST_STBY_BIT] = st_q.stby;
          st_d.rdata[DPG_ST_HIZ_BIT] = st_q.hiz;
        end
        default: st_d.rdata = DPG_RST_RD;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
      st_q.p1_dat <= DPG_RST_DAT;
      st_q.p1_dir <= DPG_RST_DIR;
      st_q.p1_pul <= DPG_RST_PUL;
      st_q.p4_dat <= DPG_RST_DAT;
      st_q.p4_dir <= DPG_RST_DIR;
      st_q.p4_pul <= DPG_RST_PUL;
      st_q.aid <= DPG_RST_AID;
      st_q.drv1.oe_b <= DPG_ALL_OFF;
      st_q.drv4.oe_b <= DPG_ALL_OFF;
    end else begin
      st_q <= st_d;
    end
  end

  assign rdata_o = st_q.rdata;
  assign port1_drv_o = st_q.drv1;
  assign port4_drv_o = st_q.drv4;
  assign port1_in_o = st_q.in1;
  assign port4_in_o = st_q.in4;

  // checks
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_b_i);

  sequence s_awake;
    !stop_mode_i && !watch_mode_i;
  endsequence

  // entry is the first cycle the registered standby flag is seen high
  sequence s_enter_stby;
    !st_q.stby ##1 st_q.stby;
  endsequence

  chk_out_latch: assert property (
    s_awake ##0 (st_q.p1_dir[0] && !port1_periph_i.oe[0])
    |=> !port1_drv_o.oe_b[0] && port1_drv_o.lvl[0] == $past(st_q.p1_dat[0])
  ) else $error("output pin not driven from latch");

  chk_input_float: assert property (
    s_awake |=> &(port4_drv_o.oe_b | $past(st_q.p4_dir | port4_periph_i.oe))
  ) else $error("input pin driven");

  chk_write_reach: assert property (
    (wr_i && addr_i == DPG_P1_DAT) ##1 (s_awake ##0 (st_q.p1_dir == 8'hFF &&
      port1_periph_i.oe == 8'h00))
    |=> port1_drv_o.lvl == $past(st_q.p1_dat, 1)
  ) else $error("written latch did not reach output");

  chk_rmw_latch: assert property (
    (rd_i && rmw_i && addr_i == DPG_P4_DAT) |=> rdata_o == $past(st_q.p4_dat)
  ) else $error("rmw read not latch");

  chk_out_read: assert property (
    (rd_i && !rmw_i && addr_i == DPG_P1_DAT && st_q.p1_dir == 8'hFF &&
     port1_periph_i.oe == 8'h00) |=> rdata_o == $past(st_q.p1_dat)
  ) else $error("output pin read not latch");

  chk_periph_own: assert property (
    s_awake ##0 port4_periph_i.oe[4]
    |=> !port4_drv_o.oe_b[4] &&
        port4_drv_o.lvl[4] == $past(port4_periph_i.dat[4])
  ) else $error("peripheral did not get pin");

  chk_pull_low: assert property (
    ~|(port1_drv_o.pu & ~port1_drv_o.oe_b & ~port1_drv_o.lvl) &&
    ~|(port4_drv_o.pu & ~port4_drv_o.oe_b & ~port4_drv_o.lvl)
  ) else $error("pull-up on while driving low");

  chk_hiz_float: assert property (
    st_q.hiz |-> port1_drv_o.oe_b == 8'hFF && port4_drv_o.oe_b == 8'hFF &&
                 port1_in_o == 8'h00
  ) else $error("standby float not applied");

  chk_hold_level: assert property (
    (st_q.stby && !st_q.hiz) [*2] |-> $stable(port1_drv_o) &&
                                       $stable(port4_drv_o)
  ) else $error("standby hold lost level");

  chk_analog_gate: assert property (
    ##1 ((port4_in_o[3:0] & ~$past(st_q.aid)) == 4'h0)
  ) else $error("analog pin digital input not blocked");

  chk_irq_live: assert property (
    (st_q.hiz && sin_irq_en_i) ##1 st_q.hiz |-> 1'b1 ##0
      (port4_in_o[DPG_SIN_PIN] == $past(lvl4[DPG_SIN_PIN]))
  ) else $error("irq pin blocked in standby");

  chk_irq_sck: assert property (
    (st_q.hiz && sck_irq_en_i) ##1 st_q.hiz |->
      port4_in_o[DPG_SCK_PIN] == $past(lvl4[DPG_SCK_PIN])
  ) else $error("clock pin blocked in standby");

  // pins without an irq role never leak a floating level inward
  chk_blocked_in: assert property (
    st_q.hiz |-> port4_in_o[4:0] == 5'h00 && !port4_in_o[6]
  ) else $error("floated pin input not blocked");

  chk_reset_clear: assert property (
    $rose(rst_b_i) |-> st_q.p1_dir == DPG_RST_DIR &&
      st_q.p4_dir == DPG_RST_DIR && st_q.aid == DPG_RST_AID
  ) else $error("direction or analog-disable not cleared by reset");

  chk_spl_taken: assert property (
    s_enter_stby |-> st_q.hiz == $past(st_q.standby_pin_state)
  ) else $error("pin-state choice not taken on standby entry");

  chk_load_latch: assert property (
    (wr_i && addr_i == DPG_P4_DAT) |=> st_q.p4_dat == $past(wdata_i)
  ) else $error("data write did not load latch");

  chk_dir_bits: assert property (
    (wr_i && addr_i == DPG_P1_DIR) |=> st_q.p1_dir == $past(wdata_i)
  ) else $error("direction write did not land");

  chk_in_read: assert property (
    (rd_i && !rmw_i && addr_i == DPG_P1_DAT && st_q.p1_dir == 8'h00 &&
     port1_periph_i.oe == 8'h00) |=> rdata_o == $past(st_q.in1)
  ) else $error("input pin read not pin level");

  chk_periph_read: assert property (
    (rd_i && !rmw_i && addr_i == DPG_P4_DAT && port4_periph_i.oe[4])
    |=> rdata_o[4] == $past(st_q.in4[4])
  ) else $error("peripheral pin read not pin level");

  chk_pullup_on: assert property (
    s_awake ##0 (st_q.p4_pul[6] && !st_q.p4_dir[6] && !port4_periph_i.oe[6])
    |=> port4_drv_o.pu[6]
  ) else $error("pull-up not connected");

  chk_rdata_idle: assert property (
    !rd_i |=> rdata_o == DPG_RST_RD
  ) else $error("read data stood past its cycle");

endmodule

// >>> rtl/dpg_pin_sync.sv
// three-stage pin synchroniser that accepts a change once the last two stages agree
`timescale 1ns/1ps
module dpg_pin_sync import dpg_pkg::*; #(
  parameter int W = 16
) (
  input wire logic mclk_i,
  input wire logic rst_b_i,
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] lvl_o
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } dpg_sync_st_t;

  dpg_sync_st_t st_q;
  dpg_sync_st_t st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pin_i;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
    // s1 feeds only s2; a bit moves when the later two stages agree
    st_d.val = (st_q.s2 & st_q.s3) | (st_q.val & (st_q.s2 | st_q.s3));
  end

  always_ff @(posedge mclk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign lvl_o = st_q.val;

endmodule

// >>> rtl/dpg_pkg.sv
// shared constants and carrier types for the dual gpio port block
package dpg_pkg;

  localparam int DPG_AW = 4;
  localparam int DPG_DW = 8;
  localparam int DPG_NA = 4;

  // register offsets
  localparam logic [DPG_AW-1:0] DPG_P1_DAT = 4'h0;
  localparam logic [DPG_AW-1:0] DPG_P1_DIR = 4'h1;
  localparam logic [DPG_AW-1:0] DPG_P1_PUL = 4'h2;
  localparam logic [DPG_AW-1:0] DPG_P4_DAT = 4'h3;
  localparam logic [DPG_AW-1:0] DPG_P4_DIR = 4'h4;
  localparam logic [DPG_AW-1:0] DPG_P4_PUL = 4'h5;
  localparam logic [DPG_AW-1:0] DPG_AID_UP = 4'h6;
  localparam logic [DPG_AW-1:0] DPG_STBY_CTL = 4'h7;
  localparam logic [DPG_AW-1:0] DPG_STATUS = 4'h8;

  // field positions
  localparam int DPG_SPL_BIT = 0;
  localparam int DPG_ST_STBY_BIT = 0;
  localparam int DPG_ST_HIZ_BIT = 1;
  localparam int DPG_SCK_PIN = 5;
  localparam int DPG_SIN_PIN = 7;

  // reset values
  localparam logic [DPG_DW-1:0] DPG_RST_DAT = 8'h00;
  localparam logic [DPG_DW-1:0] DPG_RST_DIR = 8'h00;
  localparam logic [DPG_DW-1:0] DPG_RST_PUL = 8'h00;
  localparam logic [DPG_NA-1:0] DPG_RST_AID = 4'h0;
  localparam logic [DPG_DW-1:0] DPG_RST_RD = 8'h00;
  localparam logic [DPG_DW-1:0] DPG_ALL_OFF = 8'hFF;

  // what the block drives onto one port's pads
  typedef struct packed {
    logic [DPG_DW-1:0] lvl;
    logic [DPG_DW-1:0] oe_b;
    logic [DPG_DW-1:0] pu;
  } dpg_drv_t;

  // a shared peripheral's claim on one port
  typedef struct packed {
    logic [DPG_DW-1:0] oe;
    logic [DPG_DW-1:0] dat;
  } dpg_periph_t;

endpackage

// >>> test/dpg_board_model.sv
// board-side pad model: resolves one port's pins from drivers and pull-ups
`timescale 1ns/1ps
module dpg_board_model import dpg_pkg::*; (
  input wire logic mclk_i,
  input wire dpg_drv_t drv_i,
  input wire logic [DPG_DW-1:0] ext_en_i,
  input wire logic [DPG_DW-1:0] ext_val_i,
  output logic [DPG_DW-1:0] pin_o
);
  logic flip_q = 1'b0;
  // a floating pin without pull-up wanders, so its level is never trusted
  always @(posedge mclk_i) flip_q <= ~flip_q;
  always_comb begin
    pin_o = (~drv_i.oe_b & drv_i.lvl)
      | (drv_i.oe_b & ext_en_i & ext_val_i)
      | (drv_i.oe_b & ~ext_en_i & drv_i.pu)
      | (drv_i.oe_b & ~ext_en_i & ~drv_i.pu & {DPG_DW{flip_q}});
  end
endmodule

// >>> test/dpg_gpio_test.sv
// self-checking bench for the dual gpio port block
`timescale 1ns/1ps
module dpg_gpio_test import dpg_pkg::*;;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [DPG_AW-1:0] addr = '0;
  logic [DPG_DW-1:0] wdata = '0, rdata, p1_pin, p4_pin, p1_in, p4_in;
  logic wr = 1'b0, rd = 1'b0, rmw = 1'b0;
  logic stop_m = 1'b0, watch_m = 1'b0, sck_en = 1'b0, sin_en = 1'b0;
  dpg_periph_t p1_per = '0, p4_per = '0;
  dpg_drv_t p1_drv, p4_drv;
  logic [DPG_DW-1:0] ext1_val = 8'h96, ext4_val = 8'hFF;
  logic [DPG_DW-1:0] got;
  int errors = 0;
  int comparisons = 0;

  dpg_gpio dut (.mclk_i(mclk_i), .rst_b_i(rst_b_i), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rmw_i(rmw), .rdata_o(rdata),
    .stop_mode_i(stop_m), .watch_mode_i(watch_m), .sck_irq_en_i(sck_en),
    .sin_irq_en_i(sin_en), .port1_periph_i(p1_per),
    .port4_periph_i(p4_per), .port1_pin_i(p1_pin), .port4_pin_i(p4_pin),
    .port1_drv_o(p1_drv), .port4_drv_o(p4_drv), .port1_in_o(p1_in),
    .port4_in_o(p4_in));
  dpg_board_model brd1 (.mclk_i(mclk_i), .drv_i(p1_drv),
    .ext_en_i(8'hFF), .ext_val_i(ext1_val), .pin_o(p1_pin));
  dpg_board_model brd4 (.mclk_i(mclk_i), .drv_i(p4_drv),
    .ext_en_i(8'hFF), .ext_val_i(ext4_val), .pin_o(p4_pin));

  initial begin
    forever #5 mclk_i = ~mclk_i;
  end

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask

  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge mclk_i);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rreg(input logic [3:0] a, input logic m);
    @(posedge mclk_i);
    rd <= 1'b1;
    rmw <= m;
    addr <= a;
    @(posedge mclk_i);
    rd <= 1'b0;
    rmw <= 1'b0;
    #1 got = rdata;
  endtask

  task automatic t_reset();
    logic [7:0] e;
    // let the pin synchroniser settle so input reads show the pads
    tick(4);
    for (int a = 0; a < 10; a++) begin
      rreg(a[3:0], 1'b0);
      e = (a == 0) ? ext1_val : ((a == 3) ? (ext4_val & 8'hF0) : 8'h00);
      chk(got, e);
    end
    chk(p1_drv.oe_b, 8'hFF);
    chk(p4_drv.oe_b, 8'hFF);
  endtask

  task automatic t_gpio();
    wreg(DPG_P1_DIR, 8'hF0);
    wreg(DPG_P1_DAT, 8'hA5);
    wreg(DPG_P4_DIR, 8'h01);
    tick(6);
    chk(p1_drv.oe_b, 8'h0F);
    chk(p4_drv.oe_b, 8'hFE);
    chk(p1_drv.lvl & 8'hF0, 8'hA0);
    rreg(DPG_P1_DAT, 1'b0);
    chk(got, 8'hA6);
    rreg(DPG_P1_DAT, 1'b1);
    chk(got, 8'hA5);
    wreg(DPG_P1_DAT, 8'h5A);
    tick(2);
    chk(p1_drv.lvl & 8'hF0, 8'h50);
    chk(p1_drv.oe_b, 8'h0F);
    rreg(DPG_P1_DAT, 1'b1);
    chk(got, 8'h5A);
  endtask

  task automatic t_analog();
    wreg(DPG_P4_DIR, 8'h00);
    tick(6);
    rreg(DPG_P4_DAT, 1'b0);
    chk(got, 8'hF0);
    chk(p4_in, 8'hF0);
    wreg(DPG_AID_UP, 8'hFF);
    tick(2);
    rreg(DPG_P4_DAT, 1'b0);
    chk(got, 8'hFF);
    rreg(DPG_AID_UP, 1'b0);
    chk(got, 8'h0F);
  endtask

  task automatic t_periph();
    ext4_val <= 8'h00;
    p4_per <= '{oe: 8'h10, dat: 8'h10};
    tick(2);
    chk(p4_drv.oe_b, 8'hEF);
    chk(p4_drv.lvl & 8'h10, 8'h10);
    tick(6);
    rreg(DPG_P4_DAT, 1'b0);
    chk(got, 8'h10);
    rreg(DPG_P4_DAT, 1'b1);
    chk(got, 8'h00);
    p4_per <= '0;
    tick(2);
    chk(p4_drv.oe_b, 8'hFF);
  endtask

  task automatic t_pullup();
    wreg(DPG_P1_PUL, 8'hFF);
    wreg(DPG_P1_DAT, 8'hC0);
    wreg(DPG_P4_PUL, 8'hFF);
    tick(2);
    chk(p1_drv.pu, 8'hCF);
    chk(p4_drv.pu, 8'hFF);
  endtask

  task automatic t_standby();
    ext4_val <= 8'hFF;
    sck_en <= 1'b1;
    sin_en <= 1'b1;
    wreg(DPG_P1_DIR, 8'hFF);
    wreg(DPG_P1_DAT, 8'h5A);
    wreg(DPG_STBY_CTL, 8'h01);
    stop_m <= 1'b1;
    tick(8);
    chk(p1_drv.oe_b, 8'hFF);
    chk(p1_in, 8'h00);
    chk(p4_in, 8'hA0);
    rreg(DPG_STATUS, 1'b0);
    chk(got, 8'h03);
    stop_m <= 1'b0;
    tick(3);
    chk(p1_drv.oe_b, 8'h00);
    wreg(DPG_STBY_CTL, 8'h00);
    watch_m <= 1'b1;
    tick(2);
    wreg(DPG_P1_DAT, 8'h3C);
    tick(2);
    chk(p1_drv.lvl, 8'h5A);
    chk(p1_drv.oe_b, 8'h00);
    watch_m <= 1'b0;
    tick(3);
    chk(p1_drv.lvl, 8'h3C);
  endtask

  task automatic print_verdict();
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // the whole sequence needs about 120 cycles
  initial begin
    #50000;
    errors++;
    print_verdict();
  end

  initial begin
    tick(3);
    rst_b_i <= 1'b1;
    t_reset();
    t_gpio();
    t_analog();
    t_periph();
    t_pullup();
    t_standby();
    print_verdict();
  end
endmodule
